// File: hw/link_sync.sv
// two-flop synchroniser for signals entering the ref clock domain
module link_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : link_sync

// File: hw/nibble_pair_device.sv
// nibble pair register units with byte combiner, device end of the link
// Function
// - 64 read/write 16-bit registers, 6-bit address
// - each nibble owns a separate register unit
// - combiner merges both units into one
// - nibble select is a separate link line, command bit 6
// - combiner merges read data and ready flags
// - write lands two link clocks after enable
// - host writes only while ready is high
// - self-calibration writes always win arbitration
// - colliding host write held, then completed
// - read returns the addressed register contents
// - read data one link clock after select
// - written value read back after write latency
// - register link runs on its own clock
// - link clock needed for calibration to finish
// - address selects bits of next link cycle
// - unused link drives address to zero
// - ready low until held write completes
// - rank delay writes stretch ready low
// - read when selected with write enable low
module nibble_pair_device
    import nibble_reg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    nibble_reg_if.device link,
    input wire logic cal_wr_en,
    input wire logic cal_nibble,
    input wire logic [5:0] cal_addr,
    input wire logic [15:0] cal_wdata
);
    logic link_clk_s;
    logic link_clk_prev;
    logic tick;
    logic [5:0] addr_s;
    logic [15:0] wdata_s;
    logic wr_en_s;
    logic nsel_s;
    logic [15:0] unit_rdata [2];
    logic [1:0] unit_ok;

    link_sync #(.WIDTH(25)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in({link.reg_iface_clk, link.reg_addr, link.reg_wdata, link.reg_wr_en, link.nibble_select}),
        .sync_out({link_clk_s, addr_s, wdata_s, wr_en_s, nsel_s})
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link_clk_prev <= 1'b0;
        end else begin
            link_clk_prev <= link_clk_s;
        end
    end

    // one ref cycle per rising edge of the link clock
    assign tick = link_clk_s & ~link_clk_prev;

    // unit 0 is the lower nibble, unit 1 the upper
    for (genvar n = 0; n < 2; n++) begin : g_unit
        logic [15:0] regs [REG_COUNT];
        logic sel;
        logic cal_hit;
        logic pend;
        logic [5:0] shadow_addr;
        logic [15:0] shadow_data;
        logic [1:0] hold;
        logic capture;
        logic collide;
        logic [1:0] next_hold;
        logic next_ready;

        assign sel = (n == 1) ? nsel_s : ~nsel_s;
        assign cal_hit = cal_wr_en & (cal_nibble == 1'(n));
        assign capture = sel & wr_en_s;
        assign collide = pend & cal_hit;

        always_comb begin
            next_hold = hold;
            if (capture && is_rank_reg(addr_s)) begin
                next_hold = RANK_HOLD_TICKS;
            end else if (hold != 2'h0) begin
                next_hold = hold - 2'h1;
            end
            next_ready = ~collide & (next_hold == 2'h0);
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                for (int i = 0; i < REG_COUNT; i++) begin
                    regs[i] <= REG_RESET;
                end
            end else if (tick) begin
                if (cal_hit) begin
                    regs[cal_addr] <= cal_wdata;
                end else if (pend) begin
                    regs[shadow_addr] <= shadow_data;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                pend <= 1'b0;
                shadow_addr <= 6'h00;
                shadow_data <= 16'h0000;
            end else if (tick) begin
                if (capture) begin
                    pend <= 1'b1;
                    shadow_addr <= addr_s;
                    shadow_data <= wdata_s;
                end else if (!cal_hit) begin
                    pend <= 1'b0;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                hold <= 2'h0;
                unit_ok[n] <= 1'b0;
                unit_rdata[n] <= 16'h0000;
            end else if (tick) begin
                hold <= next_hold;
                unit_ok[n] <= sel & next_ready;
                // unselected unit drives zeros so the combiner can OR
                unit_rdata[n] <= (sel && !wr_en_s) ? regs[addr_s] : 16'h0000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            link.reg_rdata <= 16'h0000;
            link.combined_ok_out <= 1'b0;
        end else begin
            link.reg_rdata <= unit_rdata[0] | unit_rdata[1];
            link.combined_ok_out <= unit_ok[0] | unit_ok[1];
        end
    end
endmodule : nibble_pair_device

// File: hw/nibble_reg_host.sv
// host controller: AXI4-Lite registers driving the nibble register link
//
// Decided for this implementation: the AXI4-Lite slave port.
module nibble_reg_host
    import nibble_reg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    nibble_reg_if.host link,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {
        IDLE = 3'b000,
        PRESEL = 3'b001,
        SETTLE = 3'b011,
        WAIT_OK = 3'b010,
        DRIVE = 3'b110,
        ISSUED = 3'b111,
        CAPTURE = 3'b101
    } host_state_e;

    host_state_e state;
    logic [2:0] phase;
    logic rise;
    logic fall;
    logic [15:0] rdata_s;
    logic ok_s;
    logic [3:0] aw_addr;
    logic aw_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_got;
    logic start;
    logic [7:0] cmd;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic busy;

    link_sync #(.WIDTH(17)) u_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in({link.reg_rdata, link.combined_ok_out}),
        .sync_out({rdata_s, ok_s})
    );

    // link clock: high for phases 0..3, low for 4..7
    assign rise = (phase == LINK_FULL_LAST);
    assign fall = (phase == LINK_HALF_LAST);
    assign busy = (state != IDLE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            phase <= 3'h0;
            link.reg_iface_clk <= 1'b0;
        end else begin
            phase <= phase + 3'h1;
            if (rise) begin
                link.reg_iface_clk <= 1'b1;
            end else if (fall) begin
                link.reg_iface_clk <= 1'b0;
            end
        end
    end

    // write channel: address and data in either order, response after both
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            start <= 1'b0;
            cmd <= 8'h00;
            wdata_reg <= 16'h0000;
        end else begin
            start <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_got <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_got <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                case (aw_addr)
                    CMD_OFFSET: begin
                        // a command while busy is dropped
                        if (!busy && w_strb[0]) begin
                            cmd <= w_data[7:0];
                            start <= 1'b1;
                        end
                    end
                    WDATA_OFFSET: begin
                        if (w_strb[0]) begin
                            wdata_reg[7:0] <= w_data[7:0];
                        end
                        if (w_strb[1]) begin
                            wdata_reg[15:8] <= w_data[15:8];
                        end
                    end
                    STATUS_OFFSET, RDATA_OFFSET: begin
                    end
                    default: begin
                        s_axi_bresp <= RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
                CMD_OFFSET: s_axi_rdata[7:0] <= cmd;
                WDATA_OFFSET: s_axi_rdata[15:0] <= wdata_reg;
                STATUS_OFFSET: begin
                    s_axi_rdata[STATUS_BUSY_BIT] <= busy;
                    s_axi_rdata[STATUS_OK_BIT] <= ok_s;
                end
                RDATA_OFFSET: s_axi_rdata[15:0] <= rdata_reg;
                default: s_axi_rresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // link sequencer: outputs change at falling link edges, inputs sampled at rising
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= IDLE;
            link.reg_addr <= 6'h00;
            link.reg_wdata <= 16'h0000;
            link.reg_wr_en <= 1'b0;
            link.nibble_select <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            case (state)
                IDLE: begin
                    if (start) begin
                        state <= PRESEL;
                    end
                end
                PRESEL: begin
                    if (fall) begin
                        // select first so ready reflects the target nibble
                        link.nibble_select <= cmd[CMD_NIBBLE_BIT];
                        link.reg_addr <= cmd[CMD_ADDR_LSB +: ADDR_W];
                        state <= SETTLE;
                    end
                end
                SETTLE: begin
                    if (rise) begin
                        state <= WAIT_OK;
                    end
                end
                WAIT_OK: begin
                    if (rise && ok_s) begin
                        state <= DRIVE;
                    end
                end
                DRIVE: begin
                    if (fall) begin
                        link.reg_wr_en <= cmd[CMD_WRITE_BIT];
                        link.reg_wdata <= cmd[CMD_WRITE_BIT] ? wdata_reg : 16'h0000;
                        state <= ISSUED;
                    end
                end
                ISSUED: begin
                    if (fall) begin
                        link.reg_wr_en <= 1'b0;
                        link.reg_wdata <= 16'h0000;
                        link.reg_addr <= 6'h00;
                        link.nibble_select <= 1'b0;
                        state <= cmd[CMD_WRITE_BIT] ? IDLE : CAPTURE;
                    end
                end
                CAPTURE: begin
                    if (rise) begin
                        rdata_reg <= rdata_s;
                        state <= IDLE;
                    end
                end
                default: begin
                    state <= IDLE;
                end
            endcase
        end
    end
endmodule : nibble_reg_host

// File: hw/nibble_reg_if.sv
// register link with 16-bit data between host controller and nibble pair
interface nibble_reg_if;
    logic reg_iface_clk;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr_en;
    logic nibble_select;
    logic [15:0] reg_rdata;
    logic combined_ok_out;

    modport device (
        input reg_iface_clk,
        input reg_addr,
        input reg_wdata,
        input reg_wr_en,
        input nibble_select,
        output reg_rdata,
        output combined_ok_out
    );
    modport host (
        output reg_iface_clk,
        output reg_addr,
        output reg_wdata,
        output reg_wr_en,
        output nibble_select,
        input reg_rdata,
        input combined_ok_out
    );
endinterface : nibble_reg_if

// File: hw/nibble_reg_pkg.sv
// shared constants for the nibble register link and its host controller
package nibble_reg_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 64;
    localparam logic [5:0] NIBBLE_CONTROL_0 = 6'h00;
    localparam logic [5:0] NIBBLE_CONTROL_1 = 6'h01;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // four read-level delay rank registers, consecutive from this base
    localparam logic [5:0] READ_LEVEL_DELAY_RANK_BASE = 6'h2C;
    localparam logic [1:0] RANK_HOLD_TICKS = 2'h2;
    // link clock made by the host: 20 MHz ref clock, 400 ns link period
    localparam int REF_CLK_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_DIV = LINK_PERIOD_NS / REF_CLK_NS;
    localparam logic [2:0] LINK_HALF_LAST = 3'(LINK_DIV / 2 - 1);
    localparam logic [2:0] LINK_FULL_LAST = 3'(LINK_DIV - 1);
    // host controller register offsets
    localparam logic [3:0] CMD_OFFSET = 4'h0;
    localparam logic [3:0] WDATA_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;
    localparam logic [3:0] RDATA_OFFSET = 4'hC;
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_NIBBLE_BIT = 6;
    localparam int CMD_WRITE_BIT = 7;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_OK_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic is_rank_reg(input logic [5:0] addr);
        return addr[5:2] == READ_LEVEL_DELAY_RANK_BASE[5:2];
    endfunction : is_rank_reg
endpackage : nibble_reg_pkg

// File: verif/nibble_reg_sva.sv
// checker for the 16-bit data register link between host and nibble pair
module nibble_reg_sva
    import nibble_reg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reg_iface_clk,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic nibble_select,
    input wire logic [15:0] reg_rdata,
    input wire logic combined_ok_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    property p_link_period;
        $rose(reg_iface_clk) |-> reg_iface_clk[*4] ##1 !reg_iface_clk[*4] ##1 reg_iface_clk;
    endproperty
    a_link_period: assert property (p_link_period)
        else $error("link clock period wrong");
    property p_wr_one_cycle;
        $rose(reg_wr_en) |-> reg_wr_en[*8] ##1 !reg_wr_en;
    endproperty
    a_wr_one_cycle: assert property (p_wr_one_cycle)
        else $error("write enable not one link cycle");
    property p_wr_stable;
        reg_wr_en && $past(reg_wr_en) |-> $stable(reg_wdata) && $stable(reg_addr) && $stable(nibble_select);
    endproperty
    a_wr_stable: assert property (p_wr_stable)
        else $error("write payload moved");
    property p_addr_on_fall;
        $changed(reg_addr) |-> $fell(reg_iface_clk);
    endproperty
    a_addr_on_fall: assert property (p_addr_on_fall)
        else $error("address changed off falling link edge");
    property p_release_zero;
        $fell(reg_wr_en) |-> reg_addr == 6'h00 && !nibble_select;
    endproperty
    a_release_zero: assert property (p_release_zero)
        else $error("link not released to zero");
    property p_wr_needs_ok;
        $rose(reg_wr_en) |-> $past(combined_ok_out, 3);
    endproperty
    a_wr_needs_ok: assert property (p_wr_needs_ok)
        else $error("write issued while not ready");
    property p_rank_drops_ok;
        $rose(reg_wr_en) && reg_addr[5:2] == READ_LEVEL_DELAY_RANK_BASE[5:2] && !nibble_select
            |-> ##8 !combined_ok_out[*8];
    endproperty
    a_rank_drops_ok: assert property (p_rank_drops_ok)
        else $error("ready did not drop after rank write");
    property p_rdata_timing;
        $changed(reg_rdata) |-> $past(reg_iface_clk, 4) && !reg_iface_clk;
    endproperty
    a_rdata_timing: assert property (p_rdata_timing)
        else $error("read data changed off its slot");
endmodule : nibble_reg_sva

// File: verif/test_nibble_register_interface.sv
// self-checking bench: AXI host controller driving the nibble pair device
module test_nibble_register_interface
    import nibble_reg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, srst, cal_wr_en, cal_nibble;
    logic [5:0] cal_addr;
    logic [15:0] cal_wdata, got;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int err_total, total_checks;

    nibble_reg_if link_bus ();
    nibble_pair_device i_nibble_pair_device (.ref_clk, .srst, .link(link_bus), .cal_wr_en, .cal_nibble,
        .cal_addr, .cal_wdata);
    nibble_reg_host i_nibble_reg_host (.ref_clk, .srst, .link(link_bus), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    nibble_reg_sva i_nibble_reg_sva (.ref_clk, .srst, .reg_iface_clk(link_bus.reg_iface_clk),
        .reg_addr(link_bus.reg_addr), .reg_wdata(link_bus.reg_wdata), .reg_wr_en(link_bus.reg_wr_en),
        .nibble_select(link_bus.nibble_select), .reg_rdata(link_bus.reg_rdata),
        .combined_ok_out(link_bus.combined_ok_out));

    task final_report;
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    task chk(input logic [15:0] got_v, input logic [15:0] exp_v);
        total_checks++;
        if (got_v !== exp_v) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask : chk

    task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task link_op(input logic wr, input logic nib, input logic [5:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        logic [31:0] s;
        logic [1:0] r;
        axi_wr(WDATA_OFFSET, {16'h0000, d}, r);
        axi_wr(CMD_OFFSET, {24'h000000, wr, nib, a}, r);
        n = 0;
        do begin
            axi_rd(STATUS_OFFSET, s, r);
            n++;
        end while (s[STATUS_BUSY_BIT] !== 1'b0 && n < 200);
        chk({15'h0000, s[STATUS_BUSY_BIT]}, 16'h0000);
        axi_rd(RDATA_OFFSET, s, r);
        q = s[15:0];
    endtask : link_op

    task t_reset_vals;
        link_op(1'b0, 1'b1, NIBBLE_CONTROL_0, 16'h0000, got);
        chk(got, REG_RESET);
        link_op(1'b0, 1'b0, NIBBLE_CONTROL_1, 16'h0000, got);
        chk(got, REG_RESET);
        // idle link selects the lower nibble, which is ready
        axi_rd(STATUS_OFFSET, rd, rsp);
        chk({15'h0000, rd[STATUS_OK_BIT]}, 16'h0001);
    endtask : t_reset_vals

    task t_write_read;
        logic [22:0] v [4];
        v = '{{1'b0, NIBBLE_CONTROL_1, 16'hE739}, {1'b1, NIBBLE_CONTROL_1, 16'h1C5A},
              {1'b0, 6'h3F, 16'hFFFF}, {1'b1, NIBBLE_CONTROL_0, 16'h8001}};
        foreach (v[i]) link_op(1'b1, v[i][22], v[i][21:16], v[i][15:0], got);
        foreach (v[i]) begin
            link_op(1'b0, v[i][22], v[i][21:16], 16'h0000, got);
            chk(got, v[i][15:0]);
        end
    endtask : t_write_read

    task t_rank;
        link_op(1'b1, 1'b0, READ_LEVEL_DELAY_RANK_BASE, 16'h0123, got);
        link_op(1'b1, 1'b0, READ_LEVEL_DELAY_RANK_BASE | 6'h01, 16'h4567, got);
        link_op(1'b0, 1'b0, READ_LEVEL_DELAY_RANK_BASE, 16'h0000, got);
        chk(got, 16'h0123);
        link_op(1'b0, 1'b0, READ_LEVEL_DELAY_RANK_BASE | 6'h01, 16'h0000, got);
        chk(got, 16'h4567);
    endtask : t_rank

    task t_collision;
        fork
            link_op(1'b1, 1'b0, 6'h05, 16'hAAAA, got);
            begin
                repeat (30) @(posedge ref_clk);
                cal_nibble <= 1'b0;
                cal_addr <= 6'h06;
                cal_wdata <= 16'h5555;
                cal_wr_en <= 1'b1;
                // three link periods so the held commit always meets it
                repeat (24) @(posedge ref_clk);
                cal_wr_en <= 1'b0;
            end
        join
        link_op(1'b0, 1'b0, 6'h05, 16'h0000, got);
        chk(got, 16'hAAAA);
        link_op(1'b0, 1'b0, 6'h06, 16'h0000, got);
        chk(got, 16'h5555);
    endtask : t_collision

    task t_axi_errs;
        axi_wr(WDATA_OFFSET, 32'h0000_A5C3, rsp);
        chk({14'h0000, rsp}, {14'h0000, RESP_OKAY});
        axi_rd(WDATA_OFFSET, rd, rsp);
        chk(rd[15:0], 16'hA5C3);
        // last link command was a lower-nibble read of 0x06
        axi_rd(CMD_OFFSET, rd, rsp);
        chk(rd[15:0], 16'h0006);
        axi_wr(4'h2, 32'h0000_00FF, rsp);
        chk({14'h0000, rsp}, {14'h0000, RESP_SLVERR});
        axi_rd(4'hA, rd, rsp);
        chk({14'h0000, rsp}, {14'h0000, RESP_SLVERR});
        chk(rd[15:0], 16'h0000);
    endtask : t_axi_errs

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        final_report();
    end

    initial begin
        srst = 1'b1;
        {cal_wr_en, cal_nibble, cal_addr, cal_wdata} = '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        err_total = 0;
        total_checks = 0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset_vals();
        t_write_read();
        t_rank();
        t_collision();
        t_axi_errs();
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset_vals();
        final_report();
    end
endmodule : test_nibble_register_interface
